//--- rtl/svr_pkg.sv
// Package for the supervisor watchdog and reset block: register map,
// field positions, reset values, time figures and the reset-control states.
// Assumes a single 20 MHz clock shared by every module of the block.
package svr_pkg;

    // Time base
    localparam longint CLK_HZ          = 20_000_000;
    localparam int     NUM_CH          = 4;            // Channels five to eight

    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] OFS_CTRL    = 8'h00;        // Watchdog enable
    localparam logic [7:0] OFS_CAP     = 8'h04;        // Timing capacitor in nF
    localparam logic [7:0] OFS_STATUS  = 8'h08;        // Sticky events, read clears
    localparam logic [7:0] OFS_MASK    = 8'h0C;        // Interrupt mask
    localparam logic [7:0] OFS_STATE   = 8'h10;        // Live state, read only

    // Field positions
    localparam int CTRL_WDOG_EN_BIT    = 0;
    localparam int CAP_W               = 16;
    localparam int EV_WDOG_BIT         = 0;            // Watchdog expired
    localparam int EV_MR_BIT           = 1;            // Manual reset pressed
    localparam int EV_UV_BIT           = 2;            // A channel fell below threshold
    localparam int EV_REL_BIT          = 3;            // Reset output released
    localparam int NUM_EV              = 4;
    localparam int ST_LEVEL_LSB        = 0;            // Four channel levels
    localparam int ST_MR_BIT           = 4;
    localparam int ST_OPEN_BIT         = 5;
    localparam int ST_RESET_BIT        = 6;
    localparam int ST_STARTUP_BIT      = 7;

    // Values after reset
    localparam logic [31:0]       CTRL_RST = 32'h0000_0001;
    localparam logic [CAP_W-1:0]  CAP_RST  = 16'h0000;
    localparam logic [NUM_EV-1:0] MASK_RST = 4'h0;

    // Synchronised pin vector: index map and idle values
    localparam int SYNC_N              = 9;
    localparam int PIN_LEVEL_LSB       = 0;
    localparam int PIN_MR              = 4;
    localparam int PIN_KICK            = 5;
    localparam int PIN_OPEN            = 6;
    localparam int PIN_TSEL            = 7;
    localparam int PIN_MARGIN          = 8;
    localparam logic [SYNC_N-1:0] SYNC_RST = 9'h19F;

    // Timing figures as printed, and their cycle counts
    localparam longint RST_TIMEOUT_MS   = 140;         // Least internal timeout
    localparam longint RST_TIMEOUT_CYC  = (RST_TIMEOUT_MS * CLK_HZ + 999) / 1000;
    localparam longint WDOG_STARTUP_S   = 54;          // Window for first kick
    localparam longint WDOG_STARTUP_CYC = WDOG_STARTUP_S * CLK_HZ;
    localparam longint WDOG_TIMEOUT_MS  = 1000;        // Plain default kick period
    localparam longint WDOG_TIMEOUT_CYC = (WDOG_TIMEOUT_MS * CLK_HZ) / 1000;
    localparam longint SRT_OHMS         = 2_060_000;   // Timeout = SRT_OHMS x C
    localparam longint SRT_CYC_PER_NF   = (SRT_OHMS * CLK_HZ) / 1_000_000_000;

    // Reset-control states, one-hot
    typedef enum logic [2:0] {
        ST_HOLD    = 3'b001,
        ST_STRETCH = 3'b010,
        ST_RUN     = 3'b100
    } svr_state_t;

endpackage

//--- rtl/svr_sync_if.sv
// Carrier for synchronised pin levels and their edge pulses.
// Assumes producer and consumer run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface svr_sync_if #(parameter int N = 9);
    logic [N-1:0] level;                 // Synchronised level
    logic [N-1:0] rise;                  // One-cycle rising edge
    logic [N-1:0] fall;                  // One-cycle falling edge
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

//--- rtl/svr_sync.sv
// Two-flop synchroniser bank with edge detection for the supervisor pins.
// Assumes pins are asynchronous to clock; edges are taken after stage two.
`timescale 1ns/10ps
`default_nettype none
module svr_sync #(
    parameter int               N       = 9,
    parameter logic [N-1:0]     RST_VAL = '0
) (
    input  wire logic           clock,   // Block clock
    input  wire logic           sys_rst, // Synchronous reset, active high
    input  wire logic [N-1:0]   pins,    // Raw pin levels
    svr_sync_if.src             sync     // Synchronised levels and edges
);
    logic [N-1:0] stage1;
    logic [N-1:0] stage2;
    logic [N-1:0] stage3;

    // Stage one feeds stage two only, to contain metastability
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
            stage3 <= RST_VAL;
        end else begin
            stage1 <= pins;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Edges compare the settled stage with its delayed copy
    assign sync.level = stage2;
    assign sync.rise  = stage2 & ~stage3;
    assign sync.fall  = ~stage2 & stage3;
endmodule // svr_sync
`default_nettype wire

//--- rtl/svr_watchdog_reset.sv
// Digital core of a multivoltage supervisor: reset stretcher, watchdog,
// per-channel fault outputs, margin override, AHB-Lite registers, interrupt.
// Assumes comparator results arrive as asynchronous digital levels.
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Stuck kick past timeout asserts reset, clears timer
// - Timer clears on reset and any kick edge
// - Startup allows 54 s for first kick
// - Open kick input disables the watchdog
// - Channel fault low while its level is low
// - Manual reset low holds reset asserted
// - Reset held one timeout after manual release
// - Capacitor timeout is 2.06e6 ohms times C
// - Supply-tied select uses internal 140 ms timeout
// - Undervoltage asserts reset, stretched after recovery
// - Margin low forces reset and every fault output high
module svr_watchdog_reset
    import svr_pkg::*;
#(
    parameter int unsigned RST_CYCLES     = 32'(RST_TIMEOUT_CYC),  // Internal timeout
    parameter int unsigned STARTUP_CYCLES = 32'(WDOG_STARTUP_CYC), // First-kick window
    parameter int unsigned WDOG_CYCLES    = 32'(WDOG_TIMEOUT_CYC)  // Kick period
) (
    input  wire logic               clock,            // 20 MHz clock
    input  wire logic               sys_rst,          // Synchronous reset, high
    input  wire logic [NUM_CH-1:0]  level_ok,         // Channels 5..8 above threshold
    input  wire logic               manual_reset_n,   // Manual reset, low active
    input  wire logic               watchdog_kick_in, // Kick level from host
    input  wire logic               kick_open,        // Kick pin left unconnected
    input  wire logic               timeout_select,   // 1: internal, 0: capacitor
    input  wire logic               margin_n,         // Margin, low forces outputs high
    output logic                    reset_n,          // Reset to host, low active
    output logic                    channel5_fault_n, // Channel 5 below threshold
    output logic                    channel6_fault_n, // Channel 6 below threshold
    output logic                    channel7_fault_n, // Channel 7 below threshold
    output logic                    channel8_fault_n, // Channel 8 below threshold
    output logic                    irq,              // Level interrupt
    input  wire logic               hsel,             // AHB select
    input  wire logic [31:0]        haddr,            // AHB address
    input  wire logic [1:0]         htrans,           // AHB transfer type
    input  wire logic               hwrite,           // AHB write
    input  wire logic [2:0]         hsize,            // AHB size
    input  wire logic [31:0]        hwdata,           // AHB write data
    input  wire logic               hready,           // AHB ready in
    output logic                    hreadyout,        // AHB ready out
    output logic                    hresp,            // AHB response
    output logic [31:0]             hrdata            // AHB read data
);
    import svr_pkg::*;

    // Elaboration checks
    if (RST_CYCLES < 1 || STARTUP_CYCLES < 1 || WDOG_CYCLES < 1) begin : g_bad_count
        $error("svr_watchdog_reset: cycle counts must be at least one");
    end

    // Synchronised pins
    svr_sync_if #(.N(SYNC_N)) sync_bus ();
    logic [SYNC_N-1:0] raw_pins;

    assign raw_pins = {margin_n, timeout_select, kick_open, watchdog_kick_in,
                       manual_reset_n, level_ok};

    // All pins pass two flops before any logic reads them
    svr_sync #(
        .N       (SYNC_N),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pins    (raw_pins),
        .sync    (sync_bus)
    );

    wire [NUM_CH-1:0] lvl_s    = sync_bus.level[PIN_LEVEL_LSB +: NUM_CH];
    wire              mr_n_s   = sync_bus.level[PIN_MR];
    wire              open_s   = sync_bus.level[PIN_OPEN];
    wire              tsel_s   = sync_bus.level[PIN_TSEL];
    wire              margin_s = sync_bus.level[PIN_MARGIN];
    wire              kick_edge = sync_bus.rise[PIN_KICK] | sync_bus.fall[PIN_KICK];

    // Registers
    logic [31:0]       ctrl;
    logic [CAP_W-1:0]  cap_nf;
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] mask;

    // Reset stretcher and watchdog state
    svr_state_t  state;
    svr_state_t  next_state;
    logic [31:0] rst_cnt;
    logic [31:0] next_rst_cnt;
    logic [31:0] wd_cnt;
    logic [31:0] next_wd_cnt;
    logic        startup;

    // Capacitor timeout in cycles; the product fits 32 bits for any 16-bit
    // capacitance, and zero capacitance is bumped to one cycle
    function automatic logic [31:0] cap_cycles(input logic [CAP_W-1:0] nf);
        logic [31:0] prod;
        prod = 32'(nf) * 32'(SRT_CYC_PER_NF);
        return (prod == 32'h0000_0000) ? 32'h0000_0001 : prod;
    endfunction

    // Timeout selection
    wire [31:0] timeout_len = tsel_s ? RST_CYCLES
                                     : cap_cycles(cap_nf);

    // Reset request sources
    wire undervolt = |(~lvl_s);
    wire hold_req  = undervolt | ~mr_n_s;

    // Watchdog gating and expiry
    wire        wd_active = ctrl[CTRL_WDOG_EN_BIT] & ~open_s
                            & (state == ST_RUN);
    wire [31:0] wd_limit  = startup ? STARTUP_CYCLES : WDOG_CYCLES;
    wire        wd_expire = wd_active & (wd_cnt >= wd_limit - 32'h0000_0001);

    // Stretch counting ends after exactly timeout_len cycles in STRETCH
    wire stretch_done = (rst_cnt >= timeout_len - 32'h0000_0001);

    // Next state of the reset controller
    always_comb begin
        next_state = state;
        case (state)
            ST_HOLD: begin
                if (!hold_req) begin
                    next_state = ST_STRETCH;
                end
            end
            ST_STRETCH: begin
                if (hold_req) begin
                    next_state = ST_HOLD;
                end else if (stretch_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (hold_req) begin
                    next_state = ST_HOLD;
                end else if (wd_expire) begin
                    next_state = ST_STRETCH;
                end
            end
            default: begin
                next_state = ST_STRETCH;
            end
        endcase
    end

    // Counters: stretch counts only while stretching, watchdog clears on
    // reset, any kick edge, its own expiry, or while disabled
    assign next_rst_cnt = (state == ST_STRETCH && !hold_req) ?
                          rst_cnt + 32'h0000_0001 : 32'h0000_0000;
    assign next_wd_cnt  = (!wd_active || kick_edge || wd_expire) ?
                          32'h0000_0000 : wd_cnt + 32'h0000_0001;

    // Controller flops; power-up starts with a full reset timeout
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state   <= ST_STRETCH;
            rst_cnt <= 32'h0000_0000;
            wd_cnt  <= 32'h0000_0000;
        end else begin
            state   <= next_state;
            rst_cnt <= next_rst_cnt;
            wd_cnt  <= next_wd_cnt;
        end
    end

    // Startup window re-arms whenever reset is asserted, ends on first edge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            startup <= 1'b1;
        end else if (state != ST_RUN) begin
            startup <= 1'b1;
        end else if (kick_edge) begin
            startup <= 1'b0;
        end
    end

    // Outputs from flops; margin overrides reset_n and every fault output but logic keeps running
    wire                next_reset_n = ~margin_s | (next_state == ST_RUN);
    wire [NUM_CH-1:0]   next_fault_n = lvl_s | {NUM_CH{~margin_s}};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reset_n          <= 1'b0;
            channel5_fault_n <= 1'b1;
            channel6_fault_n <= 1'b1;
            channel7_fault_n <= 1'b1;
            channel8_fault_n <= 1'b1;
        end else begin
            reset_n          <= next_reset_n;
            channel5_fault_n <= next_fault_n[0];
            channel6_fault_n <= next_fault_n[1];
            channel7_fault_n <= next_fault_n[2];
            channel8_fault_n <= next_fault_n[3];
        end
    end

    // AHB-Lite address-phase capture; the slave never inserts wait states
    wire        ahb_take  = hsel & hready & htrans[1];
    wire [7:0]  ahb_ofs   = {haddr[7:2], 2'b00};
    wire        hit_ctrl  = (ahb_ofs == OFS_CTRL);
    wire        hit_cap   = (ahb_ofs == OFS_CAP);
    wire        hit_stat  = (ahb_ofs == OFS_STATUS);
    wire        hit_mask  = (ahb_ofs == OFS_MASK);
    wire        hit_state = (ahb_ofs == OFS_STATE);
    wire        in_range  = (haddr[31:8] == 24'h00_0000);

    logic       wr_pend;
    logic [7:0] wr_ofs;

    // Read word formed in the address phase and held through the data phase
    wire [31:0] state_word = {24'h00_0000, startup, reset_n, open_s, mr_n_s, lvl_s};
    wire [31:0] rd_word =
        !in_range ? 32'h0000_0000 :
        hit_ctrl  ? ctrl :
        hit_cap   ? {{(32-CAP_W){1'b0}}, cap_nf} :
        hit_stat  ? {{(32-NUM_EV){1'b0}}, status} :
        hit_mask  ? {{(32-NUM_EV){1'b0}}, mask} :
        hit_state ? state_word : 32'h0000_0000;

    wire rd_status = ahb_take & ~hwrite & in_range & hit_stat;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_pend <= 1'b0;
            wr_ofs  <= 8'h00;
            hrdata  <= 32'h0000_0000;
        end else begin
            wr_pend <= ahb_take & hwrite & in_range;
            wr_ofs  <= ahb_ofs;
            hrdata  <= (ahb_take & ~hwrite) ? rd_word : hrdata;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Data-phase writes; unmapped offsets and STATUS/STATE writes are dropped
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl   <= CTRL_RST;
            cap_nf <= CAP_RST;
            mask   <= MASK_RST;
        end else if (wr_pend) begin
            ctrl   <= (wr_ofs == OFS_CTRL) ?
                      {31'h0000_0000, hwdata[CTRL_WDOG_EN_BIT]} : ctrl;
            cap_nf <= (wr_ofs == OFS_CAP)  ? hwdata[CAP_W-1:0] : cap_nf;
            mask   <= (wr_ofs == OFS_MASK) ? hwdata[NUM_EV-1:0] : mask;
        end
    end

    // Events; a new event in the clearing read's cycle survives the clear
    logic [NUM_EV-1:0] events;
    logic [NUM_EV-1:0] next_status;

    always_comb begin
        events              = '0;
        events[EV_WDOG_BIT] = wd_expire;
        events[EV_MR_BIT]   = sync_bus.fall[PIN_MR];
        events[EV_UV_BIT]   = |sync_bus.fall[PIN_LEVEL_LSB +: NUM_CH];
        events[EV_REL_BIT]  = (state != ST_RUN) & (next_state == ST_RUN);
        next_status         = (rd_status ? '0 : status) | events;
    end

    // Sticky status and the masked interrupt level
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            status <= '0;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= |(next_status & mask);
        end
    end

endmodule // svr_watchdog_reset
`default_nettype wire

//--- bench/svr_host_model.sv
// Host model: the processor side of the kick pin.
// Assumes the bench picks mode and kick spacing between scenarios.
`timescale 1ns/10ps
`default_nettype none
module svr_host_model (
    input  wire logic        clock,   // Block clock
    input  wire logic        reset_n, // Reset from the supervisor
    input  wire logic [1:0]  mode,    // 0 stuck, 1 kicking, 2 pin left open
    input  wire logic [15:0] half,    // Kick edges come half+1 cycles apart
    output var logic         kick,    // Kick level
    output var logic         open     // Pin left unconnected
);
    logic [15:0] cnt;
    initial kick = 1'b0;
    initial cnt = 16'h0000;
    // A processor held in reset cannot kick; it starts at once on release
    always @(posedge clock) begin
        cnt <= (mode != 2'd1 || !reset_n || cnt >= half) ? 16'h0000 : cnt + 16'h0001;
        // An open pin holds its level, so only the open detector or a cleared CTRL enable bit can stop expiry
        if (mode == 2'd1 && reset_n && cnt >= half)
            kick <= !kick;
    end
    // Leaving the pin open runs without a watchdog, as does clearing the CTRL enable bit
    assign open = (mode == 2'd2);
endmodule // svr_host_model
`default_nettype wire

//--- bench/svr_watchdog_reset_chk.sv
// Checker for the supervisor core: output timing against its pins.
// Assumes one clock; 3-edge pin-to-output latency as handed over.
`timescale 1ns/10ps
`default_nettype none
module svr_chk #(
    parameter int unsigned RST_CYCLES     = 20,  // Internal reset timeout
    parameter int unsigned STARTUP_CYCLES = 200  // First-kick window
) (
    input wire logic                      clock,            // Clock
    input wire logic                      sys_rst,          // Reset
    input wire logic [svr_pkg::NUM_CH-1:0] level_ok,        // Levels
    input wire logic                      manual_reset_n,   // Manual reset
    input wire logic                      watchdog_kick_in, // Kick pin
    input wire logic                      kick_open,        // Kick open
    input wire logic                      timeout_select,   // Timeout source
    input wire logic                      margin_n,         // Margin
    input wire logic                      reset_n,          // Reset out
    input wire logic                      channel5_fault_n, // Fault 5
    input wire logic                      channel6_fault_n, // Fault 6
    input wire logic                      channel7_fault_n, // Fault 7
    input wire logic                      channel8_fault_n, // Fault 8
    input wire logic                      hreadyout,        // Bus ready
    input wire logic                      hresp             // Bus response
);
    import svr_pkg::*;
    logic [31:0] ok_cnt, q_cnt, open_cnt, up_cnt;
    logic        kick_d;
    logic [3:0]  faults;
    logic        wd_clr;
    // Fault vector and the events that restart a watchdog count
    assign faults = {channel8_fault_n, channel7_fault_n, channel6_fault_n, channel5_fault_n};
    assign wd_clr = !reset_n || !margin_n || kick_open || (watchdog_kick_in != kick_d);
    // Run lengths; 32 bits cannot wrap within one run
    always_ff @(posedge clock) kick_d <= watchdog_kick_in;
    always_ff @(posedge clock) up_cnt <= sys_rst ? '0 : up_cnt + 1;
    always_ff @(posedge clock) ok_cnt <= (sys_rst || !manual_reset_n || !(&level_ok)) ? '0 : ok_cnt + 1;
    always_ff @(posedge clock) q_cnt <= (sys_rst || wd_clr) ? '0 : q_cnt + 1;
    always_ff @(posedge clock) open_cnt <= (sys_rst || !kick_open) ? '0 : open_cnt + 1;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    chk_fault_follow: assert property (
        up_cnt > 4 && $past(margin_n, 3) |-> faults == $past(level_ok, 3))
        else $error("fault outputs do not follow levels");
    chk_margin_high: assert property (
        up_cnt > 4 && !$past(margin_n, 3) |-> reset_n && (&faults))
        else $error("margin did not release outputs");
    chk_mr_holds: assert property (
        up_cnt > 4 && $past(margin_n, 3) && !$past(manual_reset_n, 3) |-> !reset_n)
        else $error("reset released during manual reset");
    chk_uv_holds: assert property (
        up_cnt > 4 && $past(margin_n, 3) && $past(level_ok, 3) != 4'hF |-> !reset_n)
        else $error("reset released during undervoltage");
    chk_stretch_len: assert property (
        $rose(reset_n) && timeout_select && $past(margin_n, 3) && $past(margin_n, 4)
        |-> ok_cnt >= RST_CYCLES) else $error("reset stretch too short");
    chk_wdog_bound: assert property (
        reset_n |-> q_cnt < STARTUP_CYCLES + 8) else $error("watchdog never expired");
    chk_open_off: assert property (
        $fell(reset_n) && open_cnt > 8 && $past(margin_n, 4)
        |-> !$past(manual_reset_n, 3) || $past(level_ok, 3) != 4'hF)
        else $error("watchdog reset with kick pin open");
    chk_bus_okay: assert property (
        hreadyout && !hresp) else $error("bus wait or error response");
    cov_mr_reset: cover property (!manual_reset_n ##3 !reset_n);
    cov_release: cover property ($rose(reset_n));
    cov_margin: cover property (!margin_n ##3 reset_n);
endmodule // svr_chk
bind svr_watchdog_reset svr_chk #(.RST_CYCLES(RST_CYCLES), .STARTUP_CYCLES(STARTUP_CYCLES))
    svr_chk_i (.clock(clock), .sys_rst(sys_rst), .level_ok(level_ok),
    .manual_reset_n(manual_reset_n), .watchdog_kick_in(watchdog_kick_in),
    .kick_open(kick_open), .timeout_select(timeout_select), .margin_n(margin_n),
    .reset_n(reset_n), .channel5_fault_n(channel5_fault_n),
    .channel6_fault_n(channel6_fault_n), .channel7_fault_n(channel7_fault_n),
    .channel8_fault_n(channel8_fault_n), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

//--- bench/tb_svr_watchdog_reset.sv
// Testbench for the supervisor core: pins, stretch, watchdog, registers.
// Assumes short counts 20/200/50 and a host model on the kick pin.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED at %0t got %h exp %h", $time, (g), (e)); end end
module tb_svr_watchdog_reset;
    import svr_pkg::*;
    localparam int unsigned T_RST = 20, T_UP = 200, T_WD = 50;
    logic        clock, sys_rst, manual_reset_n, timeout_select, margin_n;
    logic        hsel, hwrite, reset_n, irq, hreadyout, hresp, kick, open;
    logic [3:0]  level_ok, faults;
    logic [1:0]  htrans, host_mode;
    logic [2:0]  hsize;
    logic [15:0] host_half;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          err_total, n_checks;
    svr_watchdog_reset #(.RST_CYCLES(T_RST), .STARTUP_CYCLES(T_UP), .WDOG_CYCLES(T_WD))
        svr_watchdog_reset_i (.clock(clock), .sys_rst(sys_rst), .level_ok(level_ok),
        .manual_reset_n(manual_reset_n), .watchdog_kick_in(kick), .kick_open(open),
        .timeout_select(timeout_select), .margin_n(margin_n), .reset_n(reset_n),
        .channel5_fault_n(faults[0]), .channel6_fault_n(faults[1]),
        .channel7_fault_n(faults[2]), .channel8_fault_n(faults[3]), .irq(irq),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata));
    svr_host_model svr_host_model_i (.clock(clock), .reset_n(reset_n), .mode(host_mode),
        .half(host_half), .kick(kick), .open(open));
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // One single AHB-Lite transfer; waits on hready, no cycle count assumed
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Cycles until reset_n is seen high, sampled after each edge settles
    task automatic low_len(output int n);
        n = 0;
        while (reset_n !== 1'b1 && n < 60000) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask
    task automatic t_power;
        int n;
        #1 `CHK({reset_n, faults}, 5'h0F)
        low_len(n);
        `CHK(n inside {[T_RST:T_RST+4]}, 1'b1)
        ahb(0, OFS_CTRL, 0);
        `CHK(rd, CTRL_RST)
        ahb(0, OFS_MASK, 0);
        `CHK(rd, 32'(MASK_RST))
        ahb(1, OFS_CAP, 32'h0000_1234);
        ahb(0, OFS_CAP, 0);
        `CHK(rd, 32'h0000_1234)
        ahb(1, 8'h40, 32'hFFFF_FFFF);
        ahb(0, 8'h40, 0);
        `CHK(rd, 32'h0000_0000)
        $display("test power done");
    endtask
    task automatic t_faults;
        int n;
        for (int i = 0; i < NUM_CH; i++) begin
            @(posedge clock);
            level_ok <= ~(4'h1 << i);
            tick(2);
            #1 `CHK(faults, 4'hF)
            @(posedge clock);
            #1 `CHK({reset_n, faults}, {1'b0, ~(4'h1 << i)})
            @(posedge clock);
            level_ok <= 4'hF;
            low_len(n);
            `CHK(n inside {[T_RST:T_RST+5]}, 1'b1)
        end
        $display("test faults done");
    endtask
    task automatic t_mr;
        int n;
        #1 `CHK(irq, 1'b0)
        ahb(1, OFS_MASK, 32'h0000_0002);
        ahb(0, OFS_STATUS, 0);
        @(posedge clock);
        manual_reset_n <= 1'b0;
        tick(40);
        #1 `CHK({reset_n, irq}, 2'b01)
        ahb(0, OFS_STATUS, 0);
        `CHK(rd[EV_MR_BIT], 1'b1)
        tick(2);
        #1 `CHK({reset_n, irq}, 2'b00)
        @(posedge clock);
        manual_reset_n <= 1'b1;
        low_len(n);
        `CHK(n inside {[T_RST:T_RST+5]}, 1'b1)
        $display("test manual reset done");
    endtask
    task automatic t_cap;
        int n;
        @(posedge clock);
        timeout_select <= 1'b0;
        ahb(1, OFS_CAP, 32'h0000_0001);
        @(posedge clock);
        manual_reset_n <= 1'b0;
        tick(5);
        manual_reset_n <= 1'b1;
        low_len(n);
        `CHK(n inside {[41200:41205]}, 1'b1)
        @(posedge clock);
        timeout_select <= 1'b1;
        $display("test capacitor timeout done");
    endtask
    task automatic t_wdog;
        int n;
        logic k0, bad;
        bad = 1'b0;
        repeat (400) begin
            @(posedge clock);
            bad |= !reset_n;
        end
        `CHK(bad, 1'b0)
        k0 = kick;
        while (kick === k0) @(posedge clock);
        host_mode <= 2'd0;
        for (n = 0; reset_n !== 1'b0 && n < 400; n++) @(posedge clock) #1;
        `CHK(n inside {[T_WD:T_WD+6]}, 1'b1)
        low_len(n);
        `CHK(n inside {[T_RST:T_RST+4]}, 1'b1)
        for (n = 0; reset_n !== 1'b0 && n < 400; n++) @(posedge clock) #1;
        `CHK(n inside {[T_UP:T_UP+6]}, 1'b1)
        host_mode <= 2'd2;
        low_len(n);
        repeat (600) begin
            @(posedge clock);
            bad |= !reset_n;
        end
        `CHK(bad, 1'b0)
        host_mode <= 2'd1;
        $display("test watchdog done");
    endtask
    task automatic t_margin;
        int n;
        @(posedge clock);
        margin_n <= 1'b0;
        manual_reset_n <= 1'b0;
        level_ok <= 4'h0;
        tick(4);
        #1 `CHK({reset_n, faults}, 5'h1F)
        @(posedge clock);
        margin_n <= 1'b1;
        manual_reset_n <= 1'b1;
        level_ok <= 4'hF;
        low_len(n);
        $display("test margin done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Free-running 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = !clock;
    end
    // Watchdog on the run: about twice the expected length
    initial begin
        #(50 * 100000);
        err_total++;
        give_verdict();
    end
    initial begin
        {sys_rst, manual_reset_n, timeout_select, margin_n, level_ok} = 8'hFF;
        {hsel, hwrite, htrans, haddr, hwdata, err_total, n_checks} = '0;
        hsize = 3'b010;
        host_mode = 2'd1;
        host_half = 16'd20;
        tick(4);
        sys_rst <= 1'b0;
        t_power();
        t_faults();
        t_mr();
        t_cap();
        t_wdog();
        t_margin();
        give_verdict();
    end
endmodule // tb_svr_watchdog_reset
`default_nettype wire
